// *** dual_timer_control.sv ***
// Control registers and counting core of a pair of cascadable 8-bit timers
// Function
// [R1] Clock select picks fast-clock divisions or slow tick; option turns 000 into slow/8.
// [R2] Slow modes allow only codes 000 and 100; unit A adds fast clock for warm-up.
// [R3] Unit A run bit 0 stops and clears its counter; 1 starts it.
// [R4] Unit B run bit behaves the same way for its counter.
// [R5] Unit A mode 000 is 8-bit timer, 011 cascade; others are reserved.
// [R6] Unit B mode field selects its 8-bit or 16-bit operating mode.
// [R7] Software holds unit A mode at 011 for cascaded operation.
// [R8] Cascade uses unit A clock select, unit B run and flip-flop bits.
// [R9] Software leaves match registers alone while the unit counts.
// [R10] Pulse-width registers change while counting only in PWM modes.
// [R11] Unit A mode, clock and flip-flop stay unchanged while running.
// [R12] A stopping write keeps mode and clock; a starting write may change them.
// [R13] In 8-bit timer mode a match raises the request and restarts from zero.
// [R14] Registers read back as written; unit A control top bit reads zero. The code stores only bits 1:0 of the config register; its other bits read zero.
`timescale 1ns/10ps
module dual_timer_control (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Low-frequency clock tick
   input wire logic low_freq_tick,
   // Timer outputs
   output logic [1:0] counter_match_irq,
   output logic counter_b_output_flipflop
);
   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [6:0] counter_a_control;
   logic [7:0] counter_b_control;
   logic [7:0] counter_a_match_value;
   logic [7:0] counter_b_match_value;
   logic [7:0] counter_a_pulse_width_value;
   logic [7:0] counter_b_pulse_width_value;
   logic [1:0] timer_config;
   logic [7:0] count_a;
   logic [7:0] count_b;

   // Field views
   logic [2:0] counter_a_clock_select;
   logic [2:0] counter_b_clock_select;
   logic [2:0] counter_a_mode_select;
   logic [2:0] counter_b_mode_select;
   logic counter_a_run;
   logic counter_b_run;

   assign counter_a_clock_select = counter_a_control[timer_pkg::CK_LSB +: 3];
   assign counter_b_clock_select = counter_b_control[timer_pkg::CK_LSB +: 3];
   assign counter_a_mode_select = counter_a_control[timer_pkg::MODE_LSB +: 3];
   assign counter_b_mode_select = counter_b_control[timer_pkg::MODE_LSB +: 3];
   assign counter_a_run = counter_a_control[timer_pkg::RUN_BIT];
   assign counter_b_run = counter_b_control[timer_pkg::RUN_BIT];
   assign counter_b_output_flipflop = counter_b_control[timer_pkg::TFF_BIT]; // [R8]

   // Register writes; top bit of unit A control is not stored
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         counter_a_control <= timer_pkg::CTRL_RST[6:0];
         counter_b_control <= timer_pkg::CTRL_RST;
         counter_a_match_value <= timer_pkg::VALUE_RST;
         counter_b_match_value <= timer_pkg::VALUE_RST;
         counter_a_pulse_width_value <= timer_pkg::VALUE_RST;
         counter_b_pulse_width_value <= timer_pkg::VALUE_RST;
         timer_config <= timer_pkg::CFG_RST;
      end else if (reg_write) begin
         unique case (reg_addr)
            timer_pkg::ADDR_A_CTRL: counter_a_control <= reg_wdata[6:0]; // [R14]
            timer_pkg::ADDR_B_CTRL: counter_b_control <= reg_wdata;
            timer_pkg::ADDR_A_MATCH: counter_a_match_value <= reg_wdata;
            timer_pkg::ADDR_B_MATCH: counter_b_match_value <= reg_wdata;
            timer_pkg::ADDR_A_PW: counter_a_pulse_width_value <= reg_wdata;
            timer_pkg::ADDR_B_PW: counter_b_pulse_width_value <= reg_wdata;
            timer_pkg::ADDR_CFG: timer_config <= reg_wdata[1:0];
            default: ;
         endcase
      end
   end

   // Read data, one cycle after the read strobe
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= timer_pkg::ZERO8;
      end else if (reg_read) begin
         unique case (reg_addr)
            timer_pkg::ADDR_A_CTRL: reg_rdata <= {1'b0, counter_a_control}; // [R14]
            timer_pkg::ADDR_B_CTRL: reg_rdata <= counter_b_control;
            timer_pkg::ADDR_A_MATCH: reg_rdata <= counter_a_match_value;
            timer_pkg::ADDR_B_MATCH: reg_rdata <= counter_b_match_value;
            timer_pkg::ADDR_A_PW: reg_rdata <= counter_a_pulse_width_value;
            timer_pkg::ADDR_B_PW: reg_rdata <= counter_b_pulse_width_value;
            timer_pkg::ADDR_CFG: reg_rdata <= {6'h00, timer_config};
            timer_pkg::ADDR_A_COUNT: reg_rdata <= count_a;
            timer_pkg::ADDR_B_COUNT: reg_rdata <= count_b;
            default: reg_rdata <= timer_pkg::ZERO8;
         endcase
      end else begin
         reg_rdata <= timer_pkg::ZERO8;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Count clock selection
   count_clock_if cc ();
   logic cascade;
   logic warmup;

   // Cascade is entered only through unit A mode 011
   assign cascade = counter_a_mode_select == timer_pkg::MODE_A_CASCADE; // [R7]
   assign warmup = counter_b_mode_select == timer_pkg::MODE_B_WARMUP;
   // In cascade, unit A clock select drives the combined counter
   assign cc.sel[0] = counter_a_clock_select; // [R8]
   assign cc.sel[1] = counter_b_clock_select;
   assign cc.option = timer_config[timer_pkg::CFG_OPTION_BIT];
   assign cc.slow = timer_config[timer_pkg::CFG_SLOW_BIT];
   assign cc.hf_warm_ok = cascade & warmup; // [R2]

   count_clock_select u_clock_select (
      .ref_clk(ref_clk),
      .reset(reset),
      .low_freq_tick(low_freq_tick),
      .cc(cc)
   );

   // Per-unit ticks from the selector
   logic tick_a;
   logic tick_b;
   assign tick_a = cc.tick[0];
   assign tick_b = cc.tick[1];

   ////////////////////////////////////////////////////////////////////////////
   // Operating state of each unit
   timer_pkg::op_t op_a;
   timer_pkg::op_t op_b;

   // Unit A: 8-bit timer, cascade lower byte, or reserved hold
   always_comb begin
      if (cascade) begin
         op_a = timer_pkg::op_cascade;
      end else if (!counter_a_run) begin
         op_a = timer_pkg::op_stopped; // [R3]
      end else if (counter_a_mode_select == timer_pkg::MODE_A_TIMER8) begin
         op_a = timer_pkg::op_timer8; // [R5]
      end else begin
         op_a = timer_pkg::op_hold; // [R5]
      end
   end

   // Unit B: 16-bit timer and warm-up cascade, 8-bit timer, others hold
   always_comb begin
      if (!counter_b_run) begin
         op_b = timer_pkg::op_stopped; // [R4]
      end else if (cascade && (counter_b_mode_select == timer_pkg::MODE_B_TIMER16
                               || warmup)) begin
         op_b = timer_pkg::op_cascade; // [R6]
      end else if (!cascade && counter_b_mode_select == timer_pkg::MODE_B_TIMER8) begin
         op_b = timer_pkg::op_timer8; // [R6]
      end else begin
         op_b = timer_pkg::op_hold; // [R6]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Match detection
   logic hit_a;
   logic hit_b;
   logic hit16;
   assign hit_a = count_a == counter_a_match_value;
   assign hit_b = count_b == counter_b_match_value;
   // Warm-up compares the upper byte only
   assign hit16 = warmup ? hit_b : (hit_b & hit_a);

   // Unit A counter, lower byte in cascade
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         count_a <= timer_pkg::ZERO8;
      end else begin
         unique case (op_a)
            timer_pkg::op_stopped: count_a <= timer_pkg::ZERO8; // [R3]
            timer_pkg::op_timer8: begin
               if (tick_a) begin
                  count_a <= hit_a ? timer_pkg::ZERO8 : count_a + timer_pkg::ONE8; // [R13]
               end
            end
            timer_pkg::op_cascade: begin
               if (!counter_b_run) begin
                  count_a <= timer_pkg::ZERO8; // [R8]
               end else if (op_b == timer_pkg::op_cascade && tick_a) begin
                  count_a <= hit16 ? timer_pkg::ZERO8 : count_a + timer_pkg::ONE8;
               end
            end
            timer_pkg::op_hold: count_a <= count_a;
         endcase
      end
   end

   // Unit B counter, upper byte in cascade
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         count_b <= timer_pkg::ZERO8;
      end else begin
         unique case (op_b)
            timer_pkg::op_stopped: count_b <= timer_pkg::ZERO8; // [R4]
            timer_pkg::op_timer8: begin
               if (tick_b) begin
                  count_b <= hit_b ? timer_pkg::ZERO8 : count_b + timer_pkg::ONE8; // [R13]
               end
            end
            timer_pkg::op_cascade: begin
               if (tick_a && hit16) begin
                  count_b <= timer_pkg::ZERO8; // [R8]
               end else if (tick_a && count_a == timer_pkg::FULL8) begin
                  count_b <= count_b + timer_pkg::ONE8;
               end
            end
            timer_pkg::op_hold: count_b <= count_b;
         endcase
      end
   end

   // Match interrupt requests, one-cycle pulses
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         counter_match_irq <= 2'h0;
      end else begin
         counter_match_irq[0] <= op_a == timer_pkg::op_timer8 && tick_a && hit_a; // [R13]
         counter_match_irq[1] <= (op_b == timer_pkg::op_timer8 && tick_b && hit_b)
                                 || (op_b == timer_pkg::op_cascade && tick_a && hit16);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);

   property p_stop_a;
      !cascade && !counter_a_run |=> count_a == timer_pkg::ZERO8;
   endproperty
   a_stop_a: assert property (p_stop_a) else $error("unit A not cleared"); // [R3]

   property p_stop_b;
      !counter_b_run |=> count_b == timer_pkg::ZERO8;
   endproperty
   a_stop_b: assert property (p_stop_b) else $error("unit B not cleared"); // [R4]

   property p_rsv_a;
      counter_a_run && counter_a_mode_select[2] && !reg_write
         |=> count_a == $past(count_a);
   endproperty
   a_rsv_a: assert property (p_rsv_a) else $error("reserved A mode counted"); // [R5]

   property p_rsv_b;
      counter_b_run && counter_b_mode_select == timer_pkg::MODE_B_RSV && !reg_write
         |=> count_b == $past(count_b);
   endproperty
   a_rsv_b: assert property (p_rsv_b) else $error("reserved B mode counted"); // [R6]

   property p_casc_stop;
      cascade && !counter_b_run |=> count_a == timer_pkg::ZERO8
                                    && count_b == timer_pkg::ZERO8;
   endproperty
   a_casc_stop: assert property (p_casc_stop) else $error("cascade not cleared"); // [R8]

   property p_casc_step;
      op_b == timer_pkg::op_cascade && tick_a && !hit16 && !reg_write
         |=> {count_b, count_a} == $past({count_b, count_a}) + 16'h0001;
   endproperty
   a_casc_step: assert property (p_casc_step) else $error("cascade step wrong"); // [R8]

   property p_match_a;
      op_a == timer_pkg::op_timer8 && tick_a && hit_a
         |=> counter_match_irq[0] && count_a == timer_pkg::ZERO8;
   endproperty
   a_match_a: assert property (p_match_a) else $error("A match not handled"); // [R13]

   property p_match_b;
      op_b == timer_pkg::op_timer8 && tick_b && hit_b
         |=> counter_match_irq[1] && count_b == timer_pkg::ZERO8;
   endproperty
   a_match_b: assert property (p_match_b) else $error("B match not handled"); // [R13]

   property p_top_bit;
      reg_read && reg_addr == timer_pkg::ADDR_A_CTRL |=> !reg_rdata[7];
   endproperty
   a_top_bit: assert property (p_top_bit) else $error("A control top bit set"); // [R14]

   property p_readback;
      reg_write && reg_addr == timer_pkg::ADDR_B_MATCH ##1
         reg_read && reg_addr == timer_pkg::ADDR_B_MATCH && !reg_write
         |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_readback: assert property (p_readback) else $error("match readback wrong"); // [R14]

   c_irq_a: cover property (counter_match_irq[0]);
   c_irq_b: cover property (counter_match_irq[1]);
   c_cascade_irq: cover property (op_b == timer_pkg::op_cascade ##1 counter_match_irq[1]);
   c_warmup: cover property (warmup && op_b == timer_pkg::op_cascade && tick_a);
endmodule : dual_timer_control

// *** timer_pkg.sv ***
// Constants and types shared by the dual 8-bit timer control block
package timer_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_A_CTRL = 8'h1A;
   localparam logic [7:0] ADDR_B_CTRL = 8'h1B;
   localparam logic [7:0] ADDR_A_MATCH = 8'h1E;
   localparam logic [7:0] ADDR_B_MATCH = 8'h1F;
   localparam logic [7:0] ADDR_A_PW = 8'h2E;
   localparam logic [7:0] ADDR_B_PW = 8'h2F;
   localparam logic [7:0] ADDR_CFG = 8'h30;
   localparam logic [7:0] ADDR_A_COUNT = 8'h31;
   localparam logic [7:0] ADDR_B_COUNT = 8'h32;
   // Control register field positions
   localparam int MODE_LSB = 0;
   localparam int RUN_BIT = 3;
   localparam int CK_LSB = 4;
   localparam int TFF_BIT = 7;
   localparam int CFG_OPTION_BIT = 0;
   localparam int CFG_SLOW_BIT = 1;
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] VALUE_RST = 8'hFF;
   localparam logic [1:0] CFG_RST = 2'h0;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [7:0] ONE8 = 8'h01;
   localparam logic [7:0] FULL8 = 8'hFF;
   // Clock select codes
   localparam logic [2:0] CK_DIV11 = 3'h0;
   localparam logic [2:0] CK_DIV7 = 3'h1;
   localparam logic [2:0] CK_DIV5 = 3'h2;
   localparam logic [2:0] CK_DIV3 = 3'h3;
   localparam logic [2:0] CK_LF = 3'h4;
   localparam logic [2:0] CK_DIV1 = 3'h5;
   localparam logic [2:0] CK_HF = 3'h6;
   localparam logic [2:0] CK_RSV = 3'h7;
   // Divider exponents of the high-frequency clock and of the low-frequency tick
   localparam int EXP_11 = 11;
   localparam int EXP_7 = 7;
   localparam int EXP_5 = 5;
   localparam int EXP_3 = 3;
   localparam int LF_EXP = 3;
   // Mode codes of unit A
   localparam logic [2:0] MODE_A_TIMER8 = 3'h0;
   localparam logic [2:0] MODE_A_CASCADE = 3'h3;
   // Mode codes of unit B
   localparam logic [2:0] MODE_B_TIMER8 = 3'h0;
   localparam logic [2:0] MODE_B_DIVOUT = 3'h1;
   localparam logic [2:0] MODE_B_PWM8 = 3'h2;
   localparam logic [2:0] MODE_B_RSV = 3'h3;
   localparam logic [2:0] MODE_B_TIMER16 = 3'h4;
   localparam logic [2:0] MODE_B_WARMUP = 3'h5;
   localparam logic [2:0] MODE_B_PWM16 = 3'h6;
   localparam logic [2:0] MODE_B_PPG16 = 3'h7;
   // Operating state of one counter
   typedef enum logic [1:0] {op_stopped, op_timer8, op_cascade, op_hold} op_t;
endpackage : timer_pkg

// *** count_clock_if.sv ***
// Count clock request and tick lines between the timer core and the clock selector
`timescale 1ns/10ps
interface count_clock_if;
   logic [1:0][2:0] sel;
   logic option;
   logic slow;
   logic hf_warm_ok;
   logic [1:0] tick;
   modport src (input sel, input option, input slow, input hf_warm_ok, output tick);
   modport sink (output sel, output option, output slow, output hf_warm_ok, input tick);
endinterface : count_clock_if

// *** count_clock_select.sv ***
// Prescaler and per-unit count clock selection
`timescale 1ns/10ps
module count_clock_select (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Low-frequency clock tick
   input wire logic low_freq_tick,
   // Tick lines to the core
   count_clock_if.src cc
);
   logic [timer_pkg::EXP_11-1:0] hf_div;
   logic [timer_pkg::LF_EXP-1:0] lf_div;
   logic lf_div8;

   // Free-running dividers of both oscillators
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         hf_div <= '0;
      end else begin
         hf_div <= hf_div + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         lf_div <= '0;
      end else if (low_freq_tick) begin
         lf_div <= lf_div + 1'b1;
      end
   end

   assign lf_div8 = low_freq_tick & (&lf_div);

   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);

   // One selector per unit; slow modes gate illegal codes
   for (genvar g = 0; g < 2; g++) begin : g_unit
      logic raw;
      logic ok;
      always_comb begin
         raw = 1'b0;
         unique case (cc.sel[g])
            timer_pkg::CK_DIV11: raw = (cc.option | cc.slow) ? lf_div8
                                  : &hf_div[timer_pkg::EXP_11-1:0]; // [R1]
            timer_pkg::CK_DIV7: raw = &hf_div[timer_pkg::EXP_7-1:0];
            timer_pkg::CK_DIV5: raw = &hf_div[timer_pkg::EXP_5-1:0];
            timer_pkg::CK_DIV3: raw = &hf_div[timer_pkg::EXP_3-1:0];
            timer_pkg::CK_LF: raw = low_freq_tick;
            timer_pkg::CK_DIV1: raw = hf_div[0];
            timer_pkg::CK_HF: raw = 1'b1;
            timer_pkg::CK_RSV: raw = 1'b0; // [R1]
         endcase
         ok = !cc.slow || cc.sel[g] == timer_pkg::CK_DIV11
              || cc.sel[g] == timer_pkg::CK_LF
              || (g == 0 && cc.sel[g] == timer_pkg::CK_HF && cc.hf_warm_ok); // [R2]
      end
      assign cc.tick[g] = raw & ok;

      property p_full_rate_tick;
         !cc.slow && cc.sel[g] == timer_pkg::CK_HF |-> cc.tick[g];
      endproperty
      a_full_rate_tick: assert property (p_full_rate_tick)
         else $error("full-rate select did not tick"); // [R1]
      property p_slow_gate;
         cc.slow && cc.sel[g] != timer_pkg::CK_DIV11 && cc.sel[g] != timer_pkg::CK_LF
            && !(g == 0 && cc.sel[g] == timer_pkg::CK_HF && cc.hf_warm_ok) |-> !cc.tick[g];
      endproperty
      a_slow_gate: assert property (p_slow_gate)
         else $error("illegal clock ticked in slow mode"); // [R2]
   end
endmodule : count_clock_select

// *** dual_8bit_timer_control_tb_top.sv ***
// Self-checking testbench of the dual 8-bit timer control block
`timescale 1ns/10ps
module dual_8bit_timer_control_tb_top;
   localparam int LF_P = 20;
   logic ref_clk;
   logic reset;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_write;
   logic reg_read;
   logic [7:0] reg_rdata;
   logic low_freq_tick;
   logic [1:0] counter_match_irq;
   logic counter_b_output_flipflop;
   logic [7:0] a_now;
   logic [7:0] b_now;
   int lf_cnt = 0;
   int n_mismatch = 0;
   int n_checks = 0;
   int gap;
   int n;

   dual_timer_control dut (
      .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .low_freq_tick(low_freq_tick), .counter_match_irq(counter_match_irq),
      .counter_b_output_flipflop(counter_b_output_flipflop)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and low-frequency tick, one pulse every LF_P cycles
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (lf_cnt == LF_P - 1) begin
         lf_cnt <= 0;
         low_freq_tick <= 1'b1;
      end else begin
         lf_cnt <= lf_cnt + 1;
         low_freq_tick <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reporting and comparisons
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : check8
   task automatic check_num(input int got, input int exp, input string what);
      n_checks++;
      if (got != exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %0d want %0d", $time, what, got, exp);
      end
   endtask : check_num

   ////////////////////////////////////////////////////////////////////////////////
   // Register port cycles
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge ref_clk);
      reg_addr <= addr;
      reg_wdata <= data;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp, input string what);
      @(posedge ref_clk);
      reg_addr <= addr;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1;
      check8(reg_rdata, exp, what);
   endtask : rd_check
   // Stop both units with mode and clock kept, load matches, then start
   task automatic restart(input logic [7:0] ca, input logic [7:0] cb,
                          input logic [7:0] ma, input logic [7:0] mb);
      wr(timer_pkg::ADDR_A_CTRL, a_now & 8'hF7);
      wr(timer_pkg::ADDR_B_CTRL, b_now & 8'hF7);
      wr(timer_pkg::ADDR_A_MATCH, ma);
      wr(timer_pkg::ADDR_B_MATCH, mb);
      wr(timer_pkg::ADDR_A_CTRL, ca);
      wr(timer_pkg::ADDR_B_CTRL, cb);
      a_now = ca;
      b_now = cb;
   endtask : restart

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt observation: gap between two pulses, and pulse count in a window
   task automatic irq_gap(input int b, input int bound, output int g);
      int k;
      k = 0;
      while (counter_match_irq[b] !== 1'b1 && k < bound) begin
         @(posedge ref_clk);
         #1;
         k++;
      end
      @(posedge ref_clk);
      #1;
      check_num(int'(counter_match_irq[b] === 1'b1), 0, "irq pulse width");
      g = 1;
      while (counter_match_irq[b] !== 1'b1 && g < bound) begin
         @(posedge ref_clk);
         #1;
         g++;
      end
   endtask : irq_gap
   task automatic irq_count(input int b, input int cycles, output int c);
      c = 0;
      repeat (cycles) begin
         @(posedge ref_clk);
         #1;
         if (counter_match_irq[b] === 1'b1) c++;
      end
   endtask : irq_count

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_regs();
      rd_check(timer_pkg::ADDR_A_CTRL, 8'h00, "A ctrl reset");
      rd_check(timer_pkg::ADDR_B_CTRL, 8'h00, "B ctrl reset");
      rd_check(timer_pkg::ADDR_B_MATCH, 8'hFF, "B match reset");
      rd_check(timer_pkg::ADDR_B_PW, 8'hFF, "B pw reset");
      rd_check(timer_pkg::ADDR_A_PW, 8'hFF, "A pw reset");
      rd_check(timer_pkg::ADDR_A_MATCH, 8'hFF, "A match reset");
      check8(counter_b_output_flipflop, 1'b0, "flipflop reset");
      // Write then read of the B match register with no gap
      @(posedge ref_clk);
      reg_addr <= timer_pkg::ADDR_B_MATCH;
      reg_wdata <= 8'h3C;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1;
      check8(reg_rdata, 8'h3C, "B match back to back");
      wr(timer_pkg::ADDR_A_PW, 8'h5A);
      wr(timer_pkg::ADDR_B_PW, 8'hA5);
      wr(timer_pkg::ADDR_A_CTRL, 8'h87);
      wr(timer_pkg::ADDR_B_CTRL, 8'h80);
      wr(8'h20, 8'h3C);
      rd_check(timer_pkg::ADDR_A_PW, 8'h5A, "A pw");
      rd_check(timer_pkg::ADDR_B_PW, 8'hA5, "B pw");
      rd_check(timer_pkg::ADDR_A_CTRL, 8'h07, "A ctrl top bit");
      rd_check(timer_pkg::ADDR_B_CTRL, 8'h80, "B ctrl");
      check8(counter_b_output_flipflop, 1'b1, "flipflop set");
      rd_check(8'h20, 8'h00, "unmapped");
      wr(timer_pkg::ADDR_A_CTRL, 8'h00);
      wr(timer_pkg::ADDR_B_CTRL, 8'h00);
   endtask : t_regs
   task automatic t_timer8();
      restart(8'h68, 8'h60, 8'h02, 8'hFF);
      irq_gap(0, 50, gap);
      check_num(gap, 3, "A period");
      restart(8'h60, 8'h68, 8'hFF, 8'h02);
      rd_check(timer_pkg::ADDR_A_COUNT, 8'h00, "A cleared");
      irq_gap(1, 50, gap);
      check_num(gap, 3, "B period");
      restart(8'h60, 8'h60, 8'hFF, 8'hFF);
      rd_check(timer_pkg::ADDR_B_COUNT, 8'h00, "B cleared");
   endtask : t_timer8
   task automatic t_clocks();
      int tp[7];
      tp = '{2048, 128, 32, 8, LF_P, 2, 1};
      for (int c = 0; c < 7; c++) begin
         restart({1'b0, 3'(c), 4'h8}, 8'h60, 8'h01, 8'hFF);
         irq_gap(0, 5000, gap);
         check_num(gap, 2 * tp[c], "clock code period");
      end
      wr(timer_pkg::ADDR_CFG, 8'h01);
      rd_check(timer_pkg::ADDR_CFG, 8'h01, "config readback");
      restart(8'h08, 8'h60, 8'h01, 8'hFF);
      irq_gap(0, 5000, gap);
      check_num(gap, 16 * LF_P, "option code 000");
      wr(timer_pkg::ADDR_CFG, 8'h00);
      restart(8'h78, 8'h60, 8'h01, 8'hFF);
      irq_count(0, 300, n);
      check_num(n, 0, "reserved clock");
   endtask : t_clocks
   task automatic t_slow();
      logic [2:0] off[5];
      off = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
      wr(timer_pkg::ADDR_CFG, 8'h02);
      restart(8'h08, 8'h60, 8'h01, 8'hFF);
      irq_gap(0, 5000, gap);
      check_num(gap, 16 * LF_P, "slow code 000");
      restart(8'h48, 8'h60, 8'h01, 8'hFF);
      irq_gap(0, 500, gap);
      check_num(gap, 2 * LF_P, "slow code 100");
      for (int i = 0; i < 5; i++) begin
         restart({1'b0, off[i], 4'h8}, 8'h60, 8'h01, 8'hFF);
         irq_count(0, 300, n);
         check_num(n, 0, "slow fast clock");
      end
      restart(8'h63, 8'h0D, 8'h00, 8'h01);
      irq_count(1, 600, n);
      check_num(int'(n > 0), 1, "slow warm-up fast clock");
      wr(timer_pkg::ADDR_CFG, 8'h00);
   endtask : t_slow
   task automatic t_modes();
      logic [2:0] am[6];
      am = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
      for (int i = 0; i < 6; i++) begin
         restart({5'h0D, am[i]}, 8'h60, 8'h01, 8'hFF);
         irq_count(0, 60, n);
         check_num(n, 0, "A reserved mode");
      end
      for (int m = 1; m < 8; m++) begin
         restart(8'h60, {5'h0D, 3'(m)}, 8'hFF, 8'h01);
         irq_count(1, 60, n);
         check_num(n, 0, "B mode without cascade");
      end
   endtask : t_modes
   task automatic t_cascade();
      restart(8'h63, 8'h0C, 8'h00, 8'h01);
      irq_gap(1, 1000, gap);
      check_num(gap, 257, "cascade period");
      irq_count(0, 20, n);
      check_num(n, 0, "A silent in cascade");
      restart(8'h63, 8'h04, 8'hFF, 8'hFF);
      rd_check(timer_pkg::ADDR_A_COUNT, 8'h00, "cascade low cleared");
      rd_check(timer_pkg::ADDR_B_COUNT, 8'h00, "cascade high cleared");
   endtask : t_cascade

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence and watchdog
   initial begin
      reset = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
      low_freq_tick = 1'b0;
      a_now = 8'h00;
      b_now = 8'h00;
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      t_regs();
      t_timer8();
      t_clocks();
      t_slow();
      t_modes();
      t_cascade();
      wrap_up();
   end
   initial begin
      repeat (60000) @(posedge ref_clk);
      n_mismatch++;
      $display("unexpected at %0t: watchdog expired", $time);
      wrap_up();
   end
endmodule : dual_8bit_timer_control_tb_top
